// *** pnlcm_defs.svh ***
// Offsets, field positions, reset values and widths of the no-load and compute-mode register bank
`ifndef PNLCM_DEFS_SVH
`define PNLCM_DEFS_SVH

// Register indices; byte address is four times the index
`define PNLCM_IDX_NOLOAD     16'hE608
`define PNLCM_IDX_COMPUTATION_MODE   16'hE60E
`define PNLCM_IDX_IRQ_STATUS 16'hE6F0
`define PNLCM_IDX_IRQ_MASK   16'hE6F1
`define PNLCM_IDX_NOMINAL_VOLTAGE_VALUE       16'hE6F2

`define PNLCM_ADDR_W         18

// Field positions
`define PNLCM_NL_TOTAL_LSB   0
`define PNLCM_NL_FUND_LSB    3
`define PNLCM_NL_APPAR_LSB   6
`define PNLCM_IRQ_TOTAL_BIT  0
`define PNLCM_IRQ_FUND_BIT   1
`define PNLCM_IRQ_APPAR_BIT  2

// Reset values
`define PNLCM_RST_NOLOAD     16'h0000
`define PNLCM_RST_COMPUTATION_MODE   16'h01FF
`define PNLCM_RST_IRQ_MASK   3'h0
`define PNLCM_RST_NOMINAL_VOLTAGE_VALUE       24'h00_0000

`define PNLCM_NOMINAL_VOLTAGE_VALUE_W         24

`endif

// *** pnlcm_nominal_voltage_value_sel.sv ***
// Per-phase choice of measured or nominal rms voltage, and apparent power from it
`timescale 1ns/1ps
`default_nettype none

module pnlcm_nominal_voltage_value_sel #(
  parameter int VRMS_W = 24,
  parameter int IRMS_W = 24
) (
  input  wire logic                              mclk_in,
  input  wire logic                              reset_in,
  input  wire logic                              ce_in,
  input  wire logic [2:0]                        use_nominal_in,
  input  wire logic [VRMS_W-1:0]                 nominal_in,
  input  wire logic [2:0][VRMS_W-1:0]            vrms_in,
  input  wire logic [2:0][IRMS_W-1:0]            irms_in,
  output logic [2:0][VRMS_W-1:0]                 vrms_used_out,
  output logic [2:0][VRMS_W+IRMS_W-1:0]          apparent_out
);

  typedef struct packed {
    logic [2:0][VRMS_W-1:0]        vrms;
    logic [2:0][VRMS_W+IRMS_W-1:0] appar;
  } pnlcm_vsel_state_t;

  pnlcm_vsel_state_t st_q;
  pnlcm_vsel_state_t st_d;

  if (VRMS_W < 1 || IRMS_W < 1) begin : g_chk
    $error("pnlcm_nominal_voltage_value_sel: widths must be positive");
  end

  // The nominal value replaces every use of the phase voltage, the product included
  always_comb begin
    st_d = st_q;
    for (int p = 0; p < 3; p++) begin
      st_d.vrms[p]  = use_nominal_in[p] ? nominal_in : vrms_in[p];
      st_d.appar[p] = (VRMS_W+IRMS_W)'(st_d.vrms[p]) * (VRMS_W+IRMS_W)'(irms_in[p]);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      st_q <= '0;
    end else if (ce_in) begin
      st_q <= st_d;
    end
  end

  assign vrms_used_out = st_q.vrms;
  assign apparent_out  = st_q.appar;

endmodule

`default_nettype wire

// *** pnlcm_phase_sum.sv ***
// Sum of the selected phase powers feeding one pulse output
`timescale 1ns/1ps
`default_nettype none

module pnlcm_phase_sum #(
  parameter int PWR_W = 24
) (
  input  wire logic                          mclk_in,
  input  wire logic                          reset_in,
  input  wire logic                          ce_in,
  input  wire logic [2:0]                    sel_in,
  input  wire logic [2:0][PWR_W-1:0]         power_in,
  output logic signed [PWR_W+1:0]            sum_out
);

  logic signed [PWR_W+1:0] sum_q;
  logic signed [PWR_W+1:0] sum_d;

  if (PWR_W < 2) begin : g_chk
    $error("pnlcm_phase_sum: PWR_W must be at least 2");
  end

  // Cleared select bits drop their phase; all three set gives the full sum
  always_comb begin
    sum_d = '0;
    for (int p = 0; p < 3; p++) begin
      if (sel_in[p]) begin
        sum_d = sum_d + (PWR_W+2)'(signed'(power_in[p]));
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      sum_q <= '0;
    end else if (ce_in) begin
      sum_q <= sum_d;
    end
  end

  assign sum_out = sum_q;

endmodule

`default_nettype wire

// *** pnlcm_pkg.sv ***
// Types shared by the no-load and compute-mode register bank
`default_nettype none
`include "pnlcm_defs.svh"

package pnlcm_pkg;

  typedef enum logic [1:0] {
    PNLCM_ANG_VOLT_CURR,
    PNLCM_ANG_VOLT_VOLT,
    PNLCM_ANG_CURR_CURR,
    PNLCM_ANG_NONE
  } pnlcm_angle_t;

  typedef struct packed {
    logic       reserved15;
    logic       mains_band_select;
    logic [2:0] nominal_voltage_use;
    logic [1:0] angle_mode_select;
    logic [2:0] pulse_out_three_phase_select;
    logic [2:0] pulse_out_two_phase_select;
    logic [2:0] pulse_out_one_phase_select;
  } pnlcm_computation_mode_t;

  typedef struct packed {
    logic [2:0] apparent_noload_phase_bits;
    logic [2:0] fundamental_noload_phase_bits;
    logic [2:0] total_noload_phase_bits;
  } pnlcm_noload_t;

  typedef struct packed {
    pnlcm_computation_mode_t            cm;
    pnlcm_noload_t              nl;
    logic [2:0]                 irq_status;
    logic [2:0]                 irq_mask;
    logic [`PNLCM_NOMINAL_VOLTAGE_VALUE_W-1:0]   nominal_voltage_value;
    logic                       pready;
    logic                       pslverr;
    logic [31:0]                prdata;
    logic                       irq;
  } pnlcm_state_t;

endpackage

`default_nettype wire

// *** pnlcm_tb_top.sv ***
// Self-checking testbench of the no-load and compute-mode register bank
`timescale 1ns/1ps
`default_nettype none
`include "pnlcm_defs.svh"
module pnlcm_tb_top;
  localparam int W = 24;
  localparam logic [17:0] A_NL = {`PNLCM_IDX_NOLOAD, 2'b00};
  localparam logic [17:0] A_CM = {`PNLCM_IDX_COMPUTATION_MODE, 2'b00};
  localparam logic [17:0] A_ST = {`PNLCM_IDX_IRQ_STATUS, 2'b00};
  localparam logic [17:0] A_MK = {`PNLCM_IDX_IRQ_MASK, 2'b00};
  localparam logic [17:0] A_VN = {`PNLCM_IDX_NOMINAL_VOLTAGE_VALUE, 2'b00};
  logic                     clk = 1'b0;
  logic                     rst = 1'b1;
  logic                     ce = 1'b1;
  logic                     psel = 1'b0;
  logic                     pen = 1'b0;
  logic                     pwr = 1'b0;
  logic [17:0]              paddr = '0;
  logic [31:0]              pwdata = '0;
  logic [31:0]              prdata, r, cm, vn;
  logic                     pready, pslverr, irq, band, e;
  logic [8:0]               nl = '0;
  logic [2:0]               nu;
  logic [2:0][2:0][W-1:0]   pp = '0;
  logic [2:0][W-1:0]        vr = '0;
  logic [2:0][W-1:0]        ir = '0;
  logic [2:0][W-1:0]        vu;
  logic [2:0][2*W-1:0]      ap;
  logic signed [W+1:0]      s1, s2, s3;
  pnlcm_pkg::pnlcm_angle_t  ang;
  logic [31:0]              seed = 32'h0001_26d5;
  int                       mismatches = 0;
  int                       num_checks = 0;
  always #2.5 clk = ~clk;
  pnlcm_top dut (.mclk_in(clk), .reset_in(rst), .ce_in(ce), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hf), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .total_noload_phase_bits_in(nl[2:0]), .fundamental_noload_phase_bits_in(nl[5:3]),
    .apparent_noload_phase_bits_in(nl[8:6]), .pulse_power_in(pp), .vrms_in(vr), .irms_in(ir),
    .pulse_output_one_out(s1), .pulse_output_two_out(s2), .pulse_output_three_out(s3), .vrms_used_out(vu),
    .apparent_power_out(ap), .angle_mode_out(ang), .mains_band_select_out(band), .nominal_voltage_use_out(nu),
    .irq_out(irq));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Signed sum of the selected phases; widened first so three phases never overflow
  function automatic logic signed [W+1:0] psum(input logic [2:0] s, input logic [2:0][W-1:0] p);
    psum = '0;
    for (int i = 0; i < 3; i++) if (s[i]) psum += $signed(p[i]);
  endfunction
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic chk_out(input logic [63:0] g, input logic [63:0] x);
    num_checks++;
    if (g !== x) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    if (n >= 20) mismatches++;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [17:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
  task automatic rd(input logic [17:0] a); apb(1'b0, a, 32'h0000_0000); endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    test_done;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(A_CM);
    chk_reg(r, 32'h0000_01ff);
    rd(A_NL);
    chk_reg(r, 32'h0000_0000);
    $display("test reset values done");
    for (int k = 0; k < 6; k++) begin
      cm = rnd() & 32'h0000_ffff;
      if (k < 4) cm[10:9] = k[1:0];
      if (k == 4) cm[8:0] = 9'h1ff;
      if (k == 5) cm = 32'h0000_8000;
      vn = rnd() & 32'h00ff_ffff;
      for (int i = 0; i < 3; i++) begin
        vr[i] <= W'(rnd());
        ir[i] <= W'(rnd());
        for (int o = 0; o < 3; o++) pp[o][i] <= W'(rnd());
      end
      wr(A_VN, vn);
      wr(A_CM, cm);
      repeat (3) @(posedge clk);
      rd(A_CM);
      chk_reg(r, cm);
      chk_out(s1, psum(cm[2:0], pp[0]));
      chk_out(s2, psum(cm[5:3], pp[1]));
      chk_out(s3, psum(cm[8:6], pp[2]));
      chk_out(ang, cm[10:9]);
      chk_out(band, cm[14]);
      for (int i = 0; i < 3; i++) begin
        chk_out(vu[i], cm[11+i] ? vn[W-1:0] : vr[i]);
        chk_out(ap[i], (cm[11+i] ? vn[W-1:0] : vr[i]) * ir[i]);
      end
    end
    $display("test compute mode done");
    wr(A_MK, 32'h0000_0007);
    rd(A_ST);
    for (int k = 0; k < 8; k++) begin
      cm = (k == 7) ? 32'h0000_01ff : rnd() & 32'h0000_01ff;
      nl <= cm[8:0];
      repeat (3) @(posedge clk);
      chk_out(irq, |cm);
      rd(A_NL);
      chk_reg(r, cm);
      wr(A_NL, 32'hffff_ffff);
      rd(A_NL);
      chk_reg(r, cm);
      nl <= '0;
      rd(A_ST);
      chk_reg(r, {29'h0, |cm[8:6], |cm[5:3], |cm[2:0]});
      rd(A_ST);
      chk_reg(r, 32'h0000_0000);
      chk_out(irq, 1'b0);
    end
    wr(A_MK, 32'h0000_0000);
    nl <= 9'h1ff;
    repeat (3) @(posedge clk);
    chk_out(irq, 1'b0);
    nl <= '0;
    rd(A_ST);
    chk_reg(r, 32'h0000_0007);
    $display("test no-load and interrupt done");
    rd(18'h0_0000);
    chk_reg({31'h0, e}, 32'h0000_0001);
    chk_reg(r, 32'h0000_0000);
    wr(A_CM | 18'h0_0001, 32'h0000_0000);
    chk_reg({31'h0, e}, 32'h0000_0001);
    rd(A_CM);
    chk_reg(r, 32'h0000_8000);
    $display("test bus errors done");
    cm = 32'(vr[0]);
    ce <= 1'b0;
    vr[0] <= ~vr[0];
    repeat (3) @(posedge clk);
    chk_out(vu[0], cm);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    chk_out(vu[0], vr[0]);
    $display("test clock enable done");
    test_done;
  end
endmodule
`default_nettype wire

// *** pnlcm_top.sv ***
// APB register bank for per-phase no-load status and the computation mode
// What this block does
// - Bits 2:0 show per-phase no-load from total active and apparent power.
// - Any total no-load phase bit sets interrupt status bit 0 together.
// - Bits 5:3 show fundamental no-load per phase; they set status bit 1.
// - Bits 8:6 show apparent no-load per phase; they set status bit 2.
// - No-load bits 15:9 read zero; all no-load bits reset to zero.
// - Mode bits 2:0, reset one, add phases A, B, C to pulse output one.
// - Mode bits 5:3, reset one, add phases A, B, C to pulse output two.
// - Mode bits 8:6, reset one, add phases A, B, C to pulse output three.
// - All three select bits give the full sum; cleared bits drop their phase.
// - Bits 10:9 pick angle mode: V-I, V-V, I-I or none; reset 00.
// - Bits 13:11 make a phase's apparent power use the nominal voltage.
// - With nominal enabled, every use of that phase voltage takes the nominal.
// - Mode bit 15 resets zero and steers nothing.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pnlcm_defs.svh"

module pnlcm_top #(
  parameter int PWR_W  = 24,
  parameter int IRMS_W = 24
) (
  input  wire logic                                   mclk_in,
  input  wire logic                                   reset_in,
  input  wire logic                                   ce_in,
  input  wire logic                                   psel_in,
  input  wire logic                                   penable_in,
  input  wire logic                                   pwrite_in,
  input  wire logic [`PNLCM_ADDR_W-1:0]               paddr_in,
  input  wire logic [31:0]                            pwdata_in,
  input  wire logic [3:0]                             pstrb_in,
  output logic [31:0]                                 prdata_out,
  output logic                                        pready_out,
  output logic                                        pslverr_out,
  input  wire logic [2:0]                             total_noload_phase_bits_in,
  input  wire logic [2:0]                             fundamental_noload_phase_bits_in,
  input  wire logic [2:0]                             apparent_noload_phase_bits_in,
  input  wire logic [2:0][2:0][PWR_W-1:0]             pulse_power_in,
  input  wire logic [2:0][`PNLCM_NOMINAL_VOLTAGE_VALUE_W-1:0]          vrms_in,
  input  wire logic [2:0][IRMS_W-1:0]                 irms_in,
  output logic signed [PWR_W+1:0]                     pulse_output_one_out,
  output logic signed [PWR_W+1:0]                     pulse_output_two_out,
  output logic signed [PWR_W+1:0]                     pulse_output_three_out,
  output logic [2:0][`PNLCM_NOMINAL_VOLTAGE_VALUE_W-1:0]               vrms_used_out,
  output logic [2:0][`PNLCM_NOMINAL_VOLTAGE_VALUE_W+IRMS_W-1:0]        apparent_power_out,
  output pnlcm_pkg::pnlcm_angle_t                     angle_mode_out,
  output logic                                        mains_band_select_out,
  output logic [2:0]                                  nominal_voltage_use_out,
  output logic                                        irq_out
);

  pnlcm_pkg::pnlcm_state_t st_q;
  pnlcm_pkg::pnlcm_state_t st_d;

  logic                  bus_access;
  logic                  bus_first;
  logic                  bus_done;
  logic [15:0]           bus_idx;
  logic                  bus_hit;
  logic [2:0]            noload_any;

  if (PWR_W < 2 || IRMS_W < 1) begin : g_chk
    $error("pnlcm_top: PWR_W must be at least 2 and IRMS_W at least 1");
  end

  // The nominal voltage is merged from three byte lanes and read back below bit 24
  if (`PNLCM_NOMINAL_VOLTAGE_VALUE_W != 24) begin : g_chk_nominal_voltage_value
    $error("pnlcm_top: the nominal voltage must be 24 bits wide");
  end

  // Merge the two low byte lanes of a write into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] wdata,
                                          input logic [3:0]  strb);
    logic [15:0] res;
    res = old_v;
    if (strb[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (strb[1]) begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction

  // Index decode shared by the read path and the error answer
  function automatic logic idx_mapped(input logic [15:0] idx);
    logic hit;
    hit = 1'b0;
    unique case (idx)
      `PNLCM_IDX_NOLOAD,
      `PNLCM_IDX_COMPUTATION_MODE,
      `PNLCM_IDX_IRQ_STATUS,
      `PNLCM_IDX_IRQ_MASK,
      `PNLCM_IDX_NOMINAL_VOLTAGE_VALUE: hit = 1'b1;
      default:         hit = 1'b0;
    endcase
    return hit;
  endfunction

  function automatic logic [31:0] read_word(input pnlcm_pkg::pnlcm_state_t s,
                                            input logic [15:0]              idx);
    logic [31:0] res;
    res = 32'h0000_0000;
    unique case (idx)
      `PNLCM_IDX_NOLOAD:     res = {16'h0000, 7'h00, s.nl};
      `PNLCM_IDX_COMPUTATION_MODE:   res = {16'h0000, s.cm};
      `PNLCM_IDX_IRQ_STATUS: res = {29'h000_0000, s.irq_status};
      `PNLCM_IDX_IRQ_MASK:   res = {29'h000_0000, s.irq_mask};
      `PNLCM_IDX_NOMINAL_VOLTAGE_VALUE:       res = {8'h00, s.nominal_voltage_value};
      default:               res = 32'h0000_0000;
    endcase
    return res;
  endfunction

  // Answer of the first access cycle: data only for a mapped read, zero otherwise
  function automatic logic [31:0] answer_data(input pnlcm_pkg::pnlcm_state_t s,
                                              input logic [15:0]              idx,
                                              input logic                     hit,
                                              input logic                     write);
    return (hit && !write) ? read_word(s, idx) : 32'h0000_0000;
  endfunction

  // Merge the three low byte lanes of a write into the nominal voltage
  function automatic logic [`PNLCM_NOMINAL_VOLTAGE_VALUE_W-1:0] merge24(input logic [`PNLCM_NOMINAL_VOLTAGE_VALUE_W-1:0] old_v,
                                                      input logic [31:0]                 wdata,
                                                      input logic [3:0]                  strb);
    logic [`PNLCM_NOMINAL_VOLTAGE_VALUE_W-1:0] res;
    res = old_v;
    for (int b = 0; b < 3; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = wdata[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Writable registers only; the two status registers ignore writes
  function automatic pnlcm_pkg::pnlcm_state_t write_regs(input pnlcm_pkg::pnlcm_state_t s,
                                                         input logic [15:0]              idx,
                                                         input logic [31:0]              wdata,
                                                         input logic [3:0]               strb);
    pnlcm_pkg::pnlcm_state_t res;
    res = s;
    unique case (idx)
      `PNLCM_IDX_COMPUTATION_MODE: begin
        res.cm = pnlcm_pkg::pnlcm_computation_mode_t'(merge16(s.cm, wdata, strb));
      end
      `PNLCM_IDX_IRQ_MASK: begin
        if (strb[0]) begin
          res.irq_mask = wdata[2:0];
        end
      end
      `PNLCM_IDX_NOMINAL_VOLTAGE_VALUE: begin
        res.nominal_voltage_value = merge24(s.nominal_voltage_value, wdata, strb);
      end
      default: begin
        res = s;
      end
    endcase
    return res;
  endfunction

  // One summary event per detection method, raised by any of its phase bits
  function automatic logic [2:0] noload_summary(input pnlcm_pkg::pnlcm_noload_t nl);
    logic [2:0] res;
    res                       = 3'h0;
    res[`PNLCM_IRQ_TOTAL_BIT] = |nl.total_noload_phase_bits;
    res[`PNLCM_IRQ_FUND_BIT]  = |nl.fundamental_noload_phase_bits;
    res[`PNLCM_IRQ_APPAR_BIT] = |nl.apparent_noload_phase_bits;
    return res;
  endfunction

  // Clear only the bits that were returned, so an event that arrived since is kept
  function automatic logic [2:0] clear_returned(input logic [2:0] status,
                                                input logic [2:0] returned);
    return status & ~returned;
  endfunction

  // Level interrupt from the sticky flags that software has unmasked
  function automatic logic irq_level(input logic [2:0] status,
                                     input logic [2:0] mask);
    return |(status & mask);
  endfunction

  // Events come from the detector inputs, so each flag sets together with its phase bits
  assign noload_any = noload_summary({apparent_noload_phase_bits_in,
                                      fundamental_noload_phase_bits_in,
                                      total_noload_phase_bits_in});

  // Access phase takes two cycles: ready rises one cycle after penable
  assign bus_access = psel_in & penable_in;
  assign bus_first  = bus_access & ~st_q.pready;
  assign bus_done   = bus_access & st_q.pready;
  assign bus_idx    = paddr_in[`PNLCM_ADDR_W-1:2];
  assign bus_hit    = (paddr_in[1:0] == 2'b00) && idx_mapped(bus_idx);

  always_comb begin
    st_d = st_q;

    // Status follows the detectors; a write never reaches it
    st_d.nl.total_noload_phase_bits       = total_noload_phase_bits_in;
    st_d.nl.fundamental_noload_phase_bits = fundamental_noload_phase_bits_in;
    st_d.nl.apparent_noload_phase_bits    = apparent_noload_phase_bits_in;

    if (bus_first) begin
      st_d.pready  = 1'b1;
      st_d.pslverr = ~bus_hit;
      st_d.prdata  = answer_data(st_q, bus_idx, bus_hit, pwrite_in);
    end

    if (bus_done) begin
      st_d.pready  = 1'b0;
      st_d.pslverr = 1'b0;
      if (pwrite_in && bus_hit) begin
        st_d = write_regs(st_d, bus_idx, pwdata_in, pstrb_in);
      end
      if (!pwrite_in && bus_hit && bus_idx == `PNLCM_IDX_IRQ_STATUS) begin
        st_d.irq_status = clear_returned(st_q.irq_status, st_q.prdata[2:0]);
      end
    end

    // Setting wins over the read clear in the same cycle
    st_d.irq_status = st_d.irq_status | noload_any;
    st_d.irq        = irq_level(st_d.irq_status, st_d.irq_mask);
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      st_q.cm         <= pnlcm_pkg::pnlcm_computation_mode_t'(`PNLCM_RST_COMPUTATION_MODE);
      st_q.nl         <= pnlcm_pkg::pnlcm_noload_t'(9'(`PNLCM_RST_NOLOAD));
      st_q.irq_status <= 3'h0;
      st_q.irq_mask   <= `PNLCM_RST_IRQ_MASK;
      st_q.nominal_voltage_value       <= `PNLCM_RST_NOMINAL_VOLTAGE_VALUE;
      st_q.pready     <= 1'b0;
      st_q.pslverr    <= 1'b0;
      st_q.prdata     <= 32'h0000_0000;
      st_q.irq        <= 1'b0;
    end else if (ce_in) begin
      st_q <= st_d;
    end
  end

  // One summer per pulse output, each with its own phase selection
  pnlcm_phase_sum #(.PWR_W(PWR_W)) u_sum_one (
    .mclk_in  (mclk_in),
    .reset_in (reset_in),
    .ce_in    (ce_in),
    .sel_in   (st_q.cm.pulse_out_one_phase_select),
    .power_in (pulse_power_in[0]),
    .sum_out  (pulse_output_one_out)
  );

  pnlcm_phase_sum #(.PWR_W(PWR_W)) u_sum_two (
    .mclk_in  (mclk_in),
    .reset_in (reset_in),
    .ce_in    (ce_in),
    .sel_in   (st_q.cm.pulse_out_two_phase_select),
    .power_in (pulse_power_in[1]),
    .sum_out  (pulse_output_two_out)
  );

  pnlcm_phase_sum #(.PWR_W(PWR_W)) u_sum_three (
    .mclk_in  (mclk_in),
    .reset_in (reset_in),
    .ce_in    (ce_in),
    .sel_in   (st_q.cm.pulse_out_three_phase_select),
    .power_in (pulse_power_in[2]),
    .sum_out  (pulse_output_three_out)
  );

  // Nominal voltage substitution per phase
  pnlcm_nominal_voltage_value_sel #(
    .VRMS_W (`PNLCM_NOMINAL_VOLTAGE_VALUE_W),
    .IRMS_W (IRMS_W)
  ) u_nominal_voltage_value (
    .mclk_in        (mclk_in),
    .reset_in       (reset_in),
    .ce_in          (ce_in),
    .use_nominal_in (st_q.cm.nominal_voltage_use),
    .nominal_in     (st_q.nominal_voltage_value),
    .vrms_in        (vrms_in),
    .irms_in        (irms_in),
    .vrms_used_out  (vrms_used_out),
    .apparent_out   (apparent_power_out)
  );

  // Angle mode is a plain cast of the two-bit field
  assign angle_mode_out          = pnlcm_pkg::pnlcm_angle_t'(st_q.cm.angle_mode_select);
  // Band bit only goes out to the filter logic; software picks it
  assign mains_band_select_out   = st_q.cm.mains_band_select;
  assign nominal_voltage_use_out = st_q.cm.nominal_voltage_use;
  assign irq_out                 = st_q.irq;
  assign prdata_out              = st_q.prdata;
  assign pready_out              = st_q.pready;
  assign pslverr_out             = st_q.pslverr;

endmodule

`default_nettype wire

// *** pnlcm_top_properties.sv ***
// Bus and voltage-path properties of the no-load and compute-mode register bank
`timescale 1ns/1ps
`default_nettype none
`include "pnlcm_defs.svh"
module pnlcm_checker (
  input wire logic                          mclk_in,
  input wire logic                          reset_in,
  input wire logic                          ce_in,
  input wire logic                          psel_in,
  input wire logic                          penable_in,
  input wire logic                          pwrite_in,
  input wire logic [`PNLCM_ADDR_W-1:0]      paddr_in,
  input wire logic [31:0]                   prdata_out,
  input wire logic                          pready_out,
  input wire logic                          pslverr_out,
  input wire logic [2:0][`PNLCM_NOMINAL_VOLTAGE_VALUE_W-1:0] vrms_in,
  input wire logic [2:0][`PNLCM_NOMINAL_VOLTAGE_VALUE_W-1:0] vrms_used_out,
  input wire logic [2:0]                    nominal_voltage_use_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  // Taken access cycle, gated by clock enable
  sequence s_take;
    psel_in && penable_in && !pready_out && ce_in;
  endsequence
  property p_ready_pulse; pready_out && ce_in |=> !pready_out; endproperty
  property p_ready_timing; s_take |=> pready_out; endproperty
  property p_ready_cause; pready_out |-> $past(psel_in && penable_in); endproperty
  property p_err_ready; pslverr_out |-> pready_out; endproperty
  property p_err_zero; pslverr_out |-> prdata_out == 32'h0000_0000; endproperty
  property p_misaligned; s_take ##0 paddr_in[1:0] != 2'b00 |=> pslverr_out; endproperty
  property p_noload_upper;
    pready_out && !pwrite_in && paddr_in == {`PNLCM_IDX_NOLOAD, 2'b00} |-> prdata_out[31:9] == 23'h00_0000;
  endproperty
  property p_mode_mapped; s_take ##0 paddr_in == {`PNLCM_IDX_COMPUTATION_MODE, 2'b00} |=> pready_out && !pslverr_out;
  endproperty
  // Measured voltage must pass through unchanged while phase A keeps the measured path
  property p_vrms_meas;
    ce_in && !nominal_voltage_use_out[0] ##1 ce_in && !nominal_voltage_use_out[0] ##1 !nominal_voltage_use_out[0]
      |-> vrms_used_out[0] == $past(vrms_in[0]);
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready stayed high");
  a_ready_timing: assert property (p_ready_timing) else $error("ready late");
  a_ready_cause: assert property (p_ready_cause) else $error("ready without access");
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  a_err_zero: assert property (p_err_zero) else $error("error read data not zero");
  a_misaligned: assert property (p_misaligned) else $error("misaligned access accepted");
  a_noload_upper: assert property (p_noload_upper) else $error("no-load upper bits set");
  a_mode_mapped: assert property (p_mode_mapped) else $error("mode register refused");
  a_vrms_meas: assert property (p_vrms_meas) else $error("measured voltage altered");
  c_write: cover property (pready_out && pwrite_in);
  c_error: cover property (pslverr_out);
  c_nominal: cover property (nominal_voltage_use_out == 3'h7);
endmodule
bind pnlcm_top pnlcm_checker u_chk (.mclk_in(mclk_in), .reset_in(reset_in), .ce_in(ce_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .vrms_in(vrms_in), .vrms_used_out(vrms_used_out),
  .nominal_voltage_use_out(nominal_voltage_use_out));
`default_nettype wire
